// ===== supervisor_pkg.sv
// Purpose: Shared constants for the supervisor watchdog and reset block
// Assumes: pclk at 200 MHz, APB register access with 32-bit data
// Notes: Long cycle counts are defaults for top-level parameters
package supervisor_pkg;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned TRST_NS = 135000;
  // Least time, so round up to whole cycles
  localparam int unsigned TRST_CYCLES_DEF = (TRST_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned WDG_BASE_MS = 16;
  localparam int unsigned WDG_BASE_CYCLES_DEF = WDG_BASE_MS * CLK_MHZ * 1000;
  localparam int unsigned GLITCH_NS = 1000;
  localparam int unsigned GLITCH_CYCLES = (GLITCH_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned KICK_CYCLES = 1;

  // ==========================================================
  // Select strap encoding and timeout decode
  // ==========================================================
  localparam logic [1:0] SEL_GND = 2'h0;
  localparam logic [1:0] SEL_OPEN = 2'h1;
  localparam logic [1:0] SEL_SUPPLY = 2'h2;
  localparam logic [3:0] IDX_DISABLED = 4'h8;

  // ==========================================================
  // Reset output variants
  // ==========================================================
  localparam int unsigned RST_PP_HIGH = 0;
  localparam int unsigned RST_PP_LOW = 1;
  localparam int unsigned RST_OD_LOW = 2;

  // ==========================================================
  // Register map (byte addresses) and fields
  // ==========================================================
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_EVENT = 8'h04;
  localparam logic [7:0] OFF_MASK = 8'h08;
  localparam logic [7:0] OFF_COUNT = 8'h0c;
  localparam int unsigned ST_RST_BIT = 0;
  localparam int unsigned ST_FAULT_BIT = 1;
  localparam int unsigned ST_PF_BIT = 2;
  localparam int unsigned ST_DIS_BIT = 3;
  localparam int unsigned ST_STATE_LSB = 4;
  localparam int unsigned ST_IDX_LSB = 8;
  localparam int unsigned EV_W = 4;
  localparam int unsigned EV_EXPIRE = 0;
  localparam int unsigned EV_UNDERVOLT = 1;
  localparam int unsigned EV_PFAIL = 2;
  localparam int unsigned EV_RELEASE = 3;
  localparam logic [EV_W-1:0] MASK_RESET = 4'h0;

  // ==========================================================
  // Reset sequencer states, Gray along hold -> delay -> run
  // ==========================================================
  typedef enum logic [1:0]
  {
    ST_HOLD = 2'h0,
    ST_DELAY = 2'h1,
    ST_RUN = 2'h3
  } rst_state_e;

endpackage

// ===== sync_filter.sv
// Purpose: Two-flop synchroniser followed by a stability filter
// Assumes: din is asynchronous to pclk
// Notes: Output changes only after the input held STABLE_CYCLES cycles
`timescale 1ns/1ps
module sync_filter
#(
  parameter int unsigned STABLE_CYCLES = 1,
  parameter logic RESET_VAL = 1'b0
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Signal
  input wire logic din,
  output logic dout
);

  logic meta_q;
  logic sync_q;
  logic [15:0] cnt_q;
  logic dout_q;
  wire logic stable_done = (cnt_q == 16'(STABLE_CYCLES - 1));

  // ==========================================================
  // Synchroniser; meta_q feeds sync_q only
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
    end
    else
    begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  // Filter: any return to the old level restarts the count
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q <= 16'h0000;
      dout_q <= RESET_VAL;
    end
    else if (sync_q == dout_q)
      cnt_q <= 16'h0000;
    else if (stable_done)
    begin
      dout_q <= sync_q;
      cnt_q <= 16'h0000;
    end
    else
      cnt_q <= cnt_q + 16'h0001;
  end

  assign dout = dout_q;

endmodule

// ===== supervisor_watchdog_reset.sv
// Purpose: Watchdog, reset generator, fault and power-fail indicators with APB
// Assumes: presetn is the power-up condition; comparators arrive as digital levels
// Notes: Open-drain pins are driven low only, with oe high while pulling
//
// Operation
// - Kick rising edge restarts the timeout interval
// - Missed kick before expiry asserts reset
// - Both selects at supply disable watchdog
// - Eight timeouts, 16 ms to 2048 ms
// - Fault output low after a missed kick
// - Power-fail output follows monitored low level
// - Reset held during power-up and undervoltage
// - Reset pin variant chosen at build time
// - Reset asserts on any active source
// - Power-fail source: external sense or supply
// - Undervoltage glitches filtered out
// - Reset held 135 us after condition clears
// - Watchdog idle during reset, restarts after
// - Fault sticky until kick; starts released
// - Ternary selects, low digit first, open default
`timescale 1ns/1ps
module supervisor_watchdog_reset
  import supervisor_pkg::*;
#(
  parameter int unsigned TRST_CYCLES = TRST_CYCLES_DEF,
  parameter int unsigned WDG_BASE_CYCLES = WDG_BASE_CYCLES_DEF,
  parameter int unsigned RST_VARIANT = RST_PP_HIGH
)
(
  // Clock and power-up reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Host side
  input wire logic watchdog_kick_in,
  output logic rst_pin_o,
  output logic rst_pin_oe,
  // Straps and comparator levels
  input wire logic [1:0] timeout_select_low,
  input wire logic [1:0] timeout_select_high,
  input wire logic supply_low_in,
  input wire logic power_fail_sense_input,
  input wire logic pf_use_supply,
  input wire logic vcc_below_pf_in,
  // Open-drain indicators
  output logic watchdog_fault_out_o,
  output logic watchdog_fault_out_oe,
  output logic power_fail_indicator_out_o,
  output logic power_fail_indicator_out_oe,
  // Interrupt
  output logic irq
);

  // Three-level strap to digit; the unused code reads as open
  function automatic logic [3:0] trit(input logic [1:0] sel);
    if (sel == SEL_GND)
      trit = 4'h0;
    else if (sel == SEL_SUPPLY)
      trit = 4'h2;
    else
      trit = 4'h1;
  endfunction

  localparam logic RST_ON = (RST_VARIANT == RST_PP_HIGH);

  // ==========================================================
  // Declarations
  // ==========================================================
  rst_state_e state_q;
  rst_state_e state_d;
  logic [31:0] trst_cnt_q;
  logic [31:0] wdg_cnt_q;
  logic kick_prev_q;
  logic fault_q;
  logic under_prev_q;
  logic pf_prev_q;
  logic [EV_W-1:0] ev_q;
  logic [EV_W-1:0] mask_q;
  logic rst_o_q;
  logic rst_oe_q;
  logic wdo_oe_q;
  logic pfo_oe_q;
  logic irq_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [31:0] rd_mux;
  logic rd_hit;
  logic sel_event;
  logic sel_mask;
  logic kick_s;
  logic under_f;

  // ==========================================================
  // Input conditioning
  // ==========================================================
  sync_filter #(.STABLE_CYCLES(KICK_CYCLES), .RESET_VAL(1'b0)) u_kick_sync
  (
    .pclk(pclk),
    .presetn(presetn),
    .din(watchdog_kick_in),
    .dout(kick_s)
  );

  // Short dips never reach the sequencer; the reset value keeps reset safe
  sync_filter #(.STABLE_CYCLES(GLITCH_CYCLES), .RESET_VAL(1'b1)) u_under_filt
  (
    .pclk(pclk),
    .presetn(presetn),
    .din(supply_low_in),
    .dout(under_f)
  );

  // ==========================================================
  // Timeout decode and watchdog compare
  // ==========================================================
  wire logic kick_rise = kick_s & ~kick_prev_q;
  wire logic [3:0] sel_idx = trit(timeout_select_low) + 4'(3 * trit(timeout_select_high));
  wire logic wdg_dis = (sel_idx == IDX_DISABLED);
  wire logic [31:0] wdg_limit = 32'(WDG_BASE_CYCLES) << sel_idx[2:0];
  wire logic wdg_run = (state_q == ST_RUN) & ~wdg_dis;
  wire logic wdg_expire = wdg_run & ~kick_rise & (wdg_cnt_q == wdg_limit - 32'h1);
  wire logic trst_done = (trst_cnt_q == 32'(TRST_CYCLES - 1));
  wire logic pf_low = pf_use_supply ? vcc_below_pf_in : ~power_fail_sense_input;

  // ==========================================================
  // Reset sequencer
  // ==========================================================
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_HOLD:
        if (!under_f)
          state_d = ST_DELAY;
      ST_DELAY:
        if (under_f)
          state_d = ST_HOLD;
        else if (trst_done)
          state_d = ST_RUN;
      ST_RUN:
        if (under_f || wdg_expire)
          state_d = ST_HOLD;
      default:
        state_d = ST_HOLD;
    endcase
  end

  // Sequencer state and the hold-off count that follows any source clearing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= ST_HOLD;
      trst_cnt_q <= 32'h0;
    end
    else
    begin
      state_q <= state_d;
      trst_cnt_q <= (state_q == ST_DELAY && state_d == ST_DELAY) ? trst_cnt_q + 32'h1 : 32'h0;
    end
  end

  // Watchdog count; cleared while reset is out so it restarts from zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wdg_cnt_q <= 32'h0;
    else if (!wdg_run || kick_rise || wdg_expire)
      wdg_cnt_q <= 32'h0;
    else
      wdg_cnt_q <= wdg_cnt_q + 32'h1;
  end

  // Sticky fault: set on expiry, cleared only by a kick edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      kick_prev_q <= 1'b0;
      fault_q <= 1'b0;
    end
    else
    begin
      kick_prev_q <= kick_s;
      if (wdg_expire)
        fault_q <= 1'b1;
      else if (kick_rise)
        fault_q <= 1'b0;
    end
  end

  // ==========================================================
  // Pin outputs: enables and reset level from flops, open-drain data tied low
  // ==========================================================
  wire logic rst_assert_d = (state_d != ST_RUN);
  wire logic rst_o_d = (RST_VARIANT == RST_PP_HIGH) ? rst_assert_d : 1'b0;
  wire logic rst_oe_d = (RST_VARIANT == RST_OD_LOW) ? rst_assert_d : 1'b1;
  wire logic rst_lvl_d = (RST_VARIANT == RST_PP_LOW) ? ~rst_assert_d : rst_o_d;

  // Reset pin asserted from the moment power-up begins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rst_o_q <= RST_ON;
      rst_oe_q <= 1'b1;
      wdo_oe_q <= 1'b0;
      pfo_oe_q <= 1'b0;
    end
    else
    begin
      rst_o_q <= rst_lvl_d;
      rst_oe_q <= rst_oe_d;
      wdo_oe_q <= fault_q;
      pfo_oe_q <= pf_low;
    end
  end

  assign rst_pin_o = rst_o_q;
  assign rst_pin_oe = rst_oe_q;
  assign watchdog_fault_out_o = 1'b0;
  assign watchdog_fault_out_oe = wdo_oe_q;
  assign power_fail_indicator_out_o = 1'b0;
  assign power_fail_indicator_out_oe = pfo_oe_q;

  // ==========================================================
  // Events and interrupt
  // ==========================================================
  wire logic apb_access = psel & penable & ~pready_q;
  wire logic apb_done = psel & penable & pready_q;
  wire logic ev_rd = apb_done & ~pwrite & sel_event;
  wire logic [EV_W-1:0] ev_set =
  {
    (state_q != ST_RUN) & (state_d == ST_RUN),
    pf_low & ~pf_prev_q,
    under_f & ~under_prev_q,
    wdg_expire
  };
  // Only bits that went out in the read data are cleared, so a set that
  // lands between capture and clear is never lost
  wire logic [EV_W-1:0] ev_clr = ev_rd ? prdata_q[EV_W-1:0] : '0;

  // Sticky events; set beats clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ev_q <= '0;
      under_prev_q <= 1'b1;
      pf_prev_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      ev_q <= (ev_q & ~ev_clr) | ev_set;
      under_prev_q <= under_f;
      pf_prev_q <= pf_low;
      irq_q <= |(((ev_q & ~ev_clr) | ev_set) & mask_q);
    end
  end

  assign irq = irq_q;

  // ==========================================================
  // APB register file
  // ==========================================================
  always_comb
  begin
    rd_mux = 32'h0;
    rd_hit = 1'b1;
    sel_event = 1'b0;
    sel_mask = 1'b0;
    if (paddr == OFF_STATUS)
    begin
      rd_mux[ST_RST_BIT] = (state_q != ST_RUN);
      rd_mux[ST_FAULT_BIT] = fault_q;
      rd_mux[ST_PF_BIT] = pf_low;
      rd_mux[ST_DIS_BIT] = wdg_dis;
      rd_mux[ST_STATE_LSB +: 2] = state_q;
      rd_mux[ST_IDX_LSB +: 4] = sel_idx;
    end
    else if (paddr == OFF_EVENT)
    begin
      rd_mux[EV_W-1:0] = ev_q;
      sel_event = 1'b1;
    end
    else if (paddr == OFF_MASK)
    begin
      rd_mux[EV_W-1:0] = mask_q;
      sel_mask = 1'b1;
    end
    else if (paddr == OFF_COUNT)
      rd_mux = wdg_cnt_q;
    else
      rd_hit = 1'b0;
  end

  // One wait state: data and error are flops loaded in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
      mask_q <= MASK_RESET;
    end
    else
    begin
      pready_q <= apb_access;
      pslverr_q <= apb_access & ~rd_hit;
      prdata_q <= (apb_access & ~pwrite) ? rd_mux : 32'h0;
      if (apb_done && pwrite && sel_mask)
        mask_q <= pwdata[EV_W-1:0];
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

endmodule

// ===== supervisor_watchdog_reset_assertions.sv
// Purpose: Port checker for the supervisor watchdog block
// Assumes: push-pull active-high reset pin
// Notes: Age counters replace long repetitions
`timescale 1ns/1ps
module supervisor_watchdog_reset_assertions
  import supervisor_pkg::*;
#(
  parameter int unsigned TRST_CYCLES = 20
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Host, straps and levels
  input wire logic watchdog_kick_in,
  input wire logic rst_pin_o,
  input wire logic rst_pin_oe,
  input wire logic [1:0] timeout_select_low,
  input wire logic [1:0] timeout_select_high,
  input wire logic supply_low_in,
  input wire logic power_fail_sense_input,
  input wire logic pf_use_supply,
  input wire logic vcc_below_pf_in,
  // Indicators
  input wire logic watchdog_fault_out_o,
  input wire logic watchdog_fault_out_oe,
  input wire logic power_fail_indicator_out_oe
);
  localparam int UV_MAX = 210;
  logic kick_q;
  logic [11:0] kick_age_q;
  logic [15:0] rst_age_q;
  logic [8:0] low_age_q;
  wire logic pf_cond = pf_use_supply ? vcc_below_pf_in : !power_fail_sense_input;
  wire logic wdg_off = timeout_select_low == SEL_SUPPLY && timeout_select_high == SEL_SUPPLY;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================
  // Ages: last kick edge, reset pulse, undervoltage run
  // ==========================================
  // A wrapped kick_age_q or low_age_q only hides a failure; a wrapped rst_age_q can make one in AST_RST_HOLD
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      kick_q <= 1'b0;
      kick_age_q <= 12'h0;
      rst_age_q <= 16'h0;
      low_age_q <= 9'h0;
    end
    else
    begin
      kick_q <= watchdog_kick_in;
      kick_age_q <= (watchdog_kick_in && !kick_q) ? 12'h0 : kick_age_q + 12'h1;
      rst_age_q <= rst_pin_o ? rst_age_q + 16'h1 : 16'h0;
      low_age_q <= supply_low_in ? low_age_q + 9'h1 : 9'h0;
    end
  end
  // ==========================================
  // Pin relations
  // ==========================================
  AST_FAULT_PULLS_LOW:
    assert property (!watchdog_fault_out_o) else $error("fault pin high");
  AST_RST_PUSH_PULL:
    assert property (rst_pin_oe) else $error("reset pin undriven");
  AST_PF_FOLLOWS:
    assert property ($past(presetn) |-> power_fail_indicator_out_oe == $past(pf_cond))
      else $error("power-fail pin wrong");
  AST_FAULT_MEANS_RESET:
    assert property ($rose(watchdog_fault_out_oe) |-> rst_pin_o) else $error("fault, no reset");
  // Sync plus edge detect needs a few cycles, so allow a short age
  AST_FAULT_STICKY:
    assert property ($fell(watchdog_fault_out_oe) |-> kick_age_q < 12'd12)
      else $error("fault cleared without kick");
  AST_RST_HOLD:
    assert property ($fell(rst_pin_o) |-> rst_age_q >= 16'(TRST_CYCLES))
      else $error("reset pulse short");
  AST_UV_RESET:
    assert property (low_age_q > 9'(UV_MAX) |-> rst_pin_o) else $error("undervolt, no reset");
  AST_DIS_NO_EXPIRE:
    assert property (wdg_off && $past(wdg_off) && $past(wdg_off, 2) && $past(wdg_off, 3)
      |-> !$rose(watchdog_fault_out_oe)) else $error("expiry while disabled");
  // Main scenarios
  cover property ($rose(rst_pin_o) ##1 rst_pin_o);
  cover property ($fell(watchdog_fault_out_oe));
  cover property ($rose(power_fail_indicator_out_oe));
endmodule

// ===== host_mcu_model.sv
// Purpose: Host processor that kicks the watchdog
// Assumes: active-high reset pin
// Notes: Kick stays low in reset, as a halted core would leave it
`timescale 1ns/1ps
module host_mcu_model
(
  // Clock and control
  input wire logic pclk,
  input wire logic rst_active,
  input wire logic kick_on,
  // Kick line
  output logic kick
);
  // ==========================================
  // Kick generator
  // ==========================================
  // One rising edge every six cycles, inside the shortest timeout
  initial
  begin
    kick = 1'b0;
    forever
    begin
      repeat (3) @(posedge pclk);
      kick <= kick_on && !rst_active && !kick;
    end
  end
endmodule

// ===== supervisor_watchdog_reset_tb.sv
// Purpose: Self-checking bench for the supervisor watchdog block
// Assumes: shortened counts, push-pull active-high reset pin
// Notes: Host model kicks; straps and levels driven here
`timescale 1ns/1ps
module supervisor_watchdog_reset_tb
  import supervisor_pkg::*;
();
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, d;
  logic pready, pslverr, e, watchdog_kick_in, rst_pin_o, rst_pin_oe, irq;
  logic [1:0] timeout_select_low = SEL_SUPPLY, timeout_select_high = SEL_SUPPLY;
  logic supply_low_in = 1'b0, power_fail_sense_input = 1'b1, pf_use_supply = 1'b0;
  logic vcc_below_pf_in = 1'b0, kick_on = 1'b0;
  logic watchdog_fault_out_o, watchdog_fault_out_oe;
  logic power_fail_indicator_out_o, power_fail_indicator_out_oe;
  int failures = 0, tests_run = 0;
  // ==========================================
  // Design and host
  // ==========================================
  supervisor_watchdog_reset #(.TRST_CYCLES(20), .WDG_BASE_CYCLES(16)) DUT (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .watchdog_kick_in, .rst_pin_o, .rst_pin_oe, .timeout_select_low, .timeout_select_high,
    .supply_low_in, .power_fail_sense_input, .pf_use_supply, .vcc_below_pf_in,
    .watchdog_fault_out_o, .watchdog_fault_out_oe, .power_fail_indicator_out_o,
    .power_fail_indicator_out_oe, .irq);
  host_mcu_model host (.pclk, .rst_active(rst_pin_o), .kick_on, .kick(watchdog_kick_in));
  // 200 MHz clock
  initial
  begin
    forever #2.5 pclk = ~pclk;
  end
  // Compare and count
  task chk(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x)
    begin
      failures++;
      $display("mismatch at %0t: got %h exp %h", $time, g, x);
    end
  endtask
  // APB transfer; entered just after a rising edge, leaves data in d and e
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge pclk);
      n++;
    end
    // A slave that never answers counts as a mismatch, not a silent stale read
    chk({31'h0, pready}, 32'h1);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Bounded wait for the reset pin level
  task wait_rst(input logic v);
    int n;
    n = 0;
    while (rst_pin_o !== v && n < 9000)
    begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, rst_pin_o}, {31'h0, v});
  endtask
  task test_done;
    $display("tests_run=%0d failures=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Hang guard, far beyond the few thousand cycles the run needs
  initial
  begin
    #200000;
    failures++;
    test_done;
  end
  // ==========================================
  // Test sequence
  // ==========================================
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(d[ST_RST_BIT], 1);
    apb(1'b0, OFF_MASK, 32'h0);
    chk(d, MASK_RESET);
    apb(1'b0, 8'h10, 32'h0);
    chk(e, 1);
    wait_rst(1'b0);
    apb(1'b0, OFF_EVENT, 32'h0);
    chk(d[EV_RELEASE], 1);
    kick_on <= 1'b1;
    // Every strap pair, with the host kicking throughout
    for (int i = 0; i < 9; i++)
    begin
      timeout_select_low <= 2'(i % 3);
      timeout_select_high <= 2'(i / 3);
      cyc(2);
      apb(1'b0, OFF_STATUS, 32'h0);
      chk(d[11:8], i);
      chk(d[ST_DIS_BIT], i == 8);
    end
    timeout_select_low <= 2'h3;
    timeout_select_high <= SEL_GND;
    cyc(300);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(d[11:8], 1);
    chk(rst_pin_o, 0);
    apb(1'b1, OFF_MASK, 32'h1);
    apb(1'b0, OFF_MASK, 32'h0);
    chk(d, 32'h1);
    kick_on <= 1'b0;
    wait_rst(1'b1);
    cyc(2);
    chk(watchdog_fault_out_oe, 1);
    chk(irq, 1);
    apb(1'b0, OFF_COUNT, 32'h0);
    chk(d, 0);
    apb(1'b0, OFF_EVENT, 32'h0);
    chk(d[EV_EXPIRE], 1);
    cyc(2);
    chk(irq, 0);
    wait_rst(1'b0);
    chk(watchdog_fault_out_oe, 1);
    kick_on <= 1'b1;
    cyc(30);
    chk(watchdog_fault_out_oe, 0);
    timeout_select_low <= SEL_SUPPLY;
    timeout_select_high <= SEL_SUPPLY;
    cyc(2);
    kick_on <= 1'b0;
    cyc(3000);
    chk(rst_pin_o, 0);
    // Short dip is filtered, a long one resets
    supply_low_in <= 1'b1;
    cyc(150);
    supply_low_in <= 1'b0;
    cyc(60);
    chk(rst_pin_o, 0);
    supply_low_in <= 1'b1;
    cyc(250);
    chk(rst_pin_o, 1);
    chk(irq, 0);
    apb(1'b0, OFF_EVENT, 32'h0);
    chk(d[EV_UNDERVOLT], 1);
    supply_low_in <= 1'b0;
    wait_rst(1'b0);
    power_fail_sense_input <= 1'b0;
    cyc(3);
    chk(power_fail_indicator_out_oe, 1);
    chk(power_fail_indicator_out_o, 0);
    power_fail_sense_input <= 1'b1;
    pf_use_supply <= 1'b1;
    vcc_below_pf_in <= 1'b1;
    cyc(3);
    chk(power_fail_indicator_out_oe, 1);
    vcc_below_pf_in <= 1'b0;
    cyc(3);
    chk(power_fail_indicator_out_oe, 0);
    apb(1'b0, OFF_EVENT, 32'h0);
    chk(d[EV_PFAIL], 1);
    test_done;
  end
endmodule
bind supervisor_watchdog_reset supervisor_watchdog_reset_assertions
  #(.TRST_CYCLES(TRST_CYCLES)) chk_u (.pclk, .presetn, .watchdog_kick_in, .rst_pin_o,
  .rst_pin_oe, .timeout_select_low, .timeout_select_high, .supply_low_in,
  .power_fail_sense_input, .pf_use_supply, .vcc_below_pf_in, .watchdog_fault_out_o,
  .watchdog_fault_out_oe, .power_fail_indicator_out_oe);
